// *** design/dmas_top.sv ***
// dma address generation, adc scan sequencing and status, apb slave
//
// What this block does
// - high nibble register upper bits give end top
// - start address is low nibble plus start byte
// - end address is end nibble plus end byte
// - start byte write loads the start address
// - current address steps one or two per transfer
// - start byte read returns current address low
// - adc address is base[7:1], input, zero
// - result high byte even, low byte odd
// - adc disabled ignores conversions, input forced zero
// - adc interrupt only after last input, if enabled
// - count field selects inputs zero through n
// - scan starts at zero, steps up one
// - status bits 7..4 show current input
// - status read clears all three flags
// - status bit 2 set at adc scan end
// - status bits 1,0 set at channel end
// - at end address reload start, single pass disables
// - channel with irq enable flags at end
// - after last input return to zero, else next
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dmas_top
  import dmas_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // general channel transfer completions (one pulse per finished transfer)
  input wire logic [1:0] chan_xfer_done,
  // adc result ready, with 10-bit result
  input wire logic adc_result_valid,
  input wire logic [9:0] adc_result,
  // register file write port for adc results
  output logic rf_we,
  output logic [11:0] rf_addr,
  output logic [7:0] rf_wdata,
  // per channel current address and end address toward the bus engine
  output logic [23:0] chan_cur_addr,
  output logic [23:0] chan_end_addr,
  output logic [1:0] chan_enable,
  output logic [1:0] chan_word,
  // adc input select and conversion start
  output logic [3:0] current_input_number,
  output logic adc_start,
  // dma interrupt request
  output logic dma_irq
);
  logic [7:0] hi_q [2];
  logic [7:0] start_q [2];
  logic [7:0] end_q [2];
  logic [11:0] cur_q [2];
  logic [7:0] ctl_q [2];
  logic [7:0] base_q;
  logic [7:0] actl_q;
  logic [3:0] inp_q;
  logic [2:0] flag_q;
  logic [1:0] ch_end_ev;
  logic adc_pend_q;
  logic [7:0] adc_low_q;
  logic adc_last_ev;
  logic [2:0] flag_set;
  logic wr_en, rd_en;
  logic [11:0] idx;
  logic [7:0] rd_d;
  logic [1:0] wr_start, wr_hi;

  assign idx = paddr[ADDR_W-1:2];
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign adc_last_ev = adc_result_valid & actl_q[ACTL_EN] &
                       (inp_q >= actl_q[ACTL_CNT_LO +: 4]);
  assign flag_set[ST_ADC] = adc_last_ev & actl_q[ACTL_IRQ];
  assign flag_set[ST_CH1] = ch_end_ev[1] & ctl_q[1][CTL_IRQ];
  assign flag_set[ST_CH0] = ch_end_ev[0] & ctl_q[0][CTL_IRQ];

  // apb: zero wait states, no error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
    end
  end

  // general channels
  genvar g;
  for (g = 0; g < 2; g++) begin : g_chan
    logic [11:0] start_full, end_full;
    logic [11:0] hi_idx, st_idx, en_idx, ct_idx;
    assign hi_idx = (g == 0) ? IDX_CH0_HI : IDX_CH1_HI;
    assign st_idx = (g == 0) ? IDX_CH0_START : IDX_CH1_START;
    assign en_idx = (g == 0) ? IDX_CH0_END : IDX_CH1_END;
    assign ct_idx = (g == 0) ? IDX_CH0_CTL : IDX_CH1_CTL;
    assign start_full = {hi_q[g][3:0], start_q[g]};
    assign end_full = {hi_q[g][7:4], end_q[g]};
    assign wr_start[g] = wr_en & (idx == st_idx);
    assign wr_hi[g] = wr_en & (idx == hi_idx);
    assign ch_end_ev[g] = chan_xfer_done[g] & ctl_q[g][CTL_EN] &
                          (cur_q[g] == end_full);

    always_ff @(posedge pclk) begin
      if (wr_en && idx == hi_idx) hi_q[g] <= pwdata[7:0];
      if (wr_en && idx == st_idx) start_q[g] <= pwdata[7:0];
      if (wr_en && idx == en_idx) end_q[g] <= pwdata[7:0];
    end

    // current address: loaded by start writes, stepped per transfer
    always_ff @(posedge pclk) begin
      if (wr_start[g] || wr_hi[g]) begin
        cur_q[g] <= wr_start[g] ? {hi_q[g][3:0], pwdata[7:0]}
                                : {pwdata[3:0], start_q[g]};
      end else if (ch_end_ev[g]) begin
        cur_q[g] <= start_full;
      end else if (chan_xfer_done[g] && ctl_q[g][CTL_EN]) begin
        cur_q[g] <= cur_q[g] + (ctl_q[g][CTL_WORD] ? STEP_WORD
                                                    : STEP_BYTE);
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ctl_q[g] <= RST_CTL;
      end else if (wr_en && idx == ct_idx) begin
        ctl_q[g] <= pwdata[7:0];
      end else if (ch_end_ev[g] && !ctl_q[g][CTL_LOOP]) begin
        ctl_q[g][CTL_EN] <= 1'b0;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        chan_cur_addr[g*12 +: 12] <= 12'h000;
        chan_end_addr[g*12 +: 12] <= 12'h000;
        chan_enable[g] <= 1'b0;
        chan_word[g] <= 1'b0;
      end else begin
        chan_cur_addr[g*12 +: 12] <= cur_q[g];
        chan_end_addr[g*12 +: 12] <= end_full;
        chan_enable[g] <= ctl_q[g][CTL_EN];
        chan_word[g] <= ctl_q[g][CTL_WORD];
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_en && idx == IDX_ADC_BASE) base_q <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) actl_q <= RST_CTL;
    else if (wr_en && idx == IDX_ADC_CTL) actl_q <= pwdata[7:0];
  end

  // adc scan sequencing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inp_q <= INPUT_ZERO;
      adc_start <= 1'b0;
    end else if (!actl_q[ACTL_EN]) begin
      inp_q <= INPUT_ZERO;
      adc_start <= 1'b0;
    end else if (adc_result_valid) begin
      inp_q <= adc_last_ev ? INPUT_ZERO : inp_q + 4'h1;
      adc_start <= 1'b1;
    end else begin
      adc_start <= 1'b0;
    end
  end

  // result written high byte at even address, then low at odd
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_we <= 1'b0;
      rf_addr <= 12'h000;
      rf_wdata <= 8'h00;
      adc_pend_q <= 1'b0;
      adc_low_q <= 8'h00;
    end else if (adc_result_valid && actl_q[ACTL_EN]) begin
      rf_we <= 1'b1;
      rf_addr <= {base_q[7:1], inp_q, 1'b0};
      rf_wdata <= adc_result[9:2];
      adc_pend_q <= 1'b1;
      adc_low_q <= {adc_result[1:0], 6'h00};
    end else if (adc_pend_q) begin
      rf_we <= 1'b1;
      rf_addr <= {rf_addr[11:1], 1'b1};
      rf_wdata <= adc_low_q;
      adc_pend_q <= 1'b0;
    end else begin
      rf_we <= 1'b0;
    end
  end

  // status flags: set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 3'b000;
    end else begin
      if (rd_en && idx == IDX_STATUS) flag_q <= 3'b000;
      if (flag_set[ST_ADC]) flag_q[ST_ADC] <= 1'b1;
      if (flag_set[ST_CH1]) flag_q[ST_CH1] <= 1'b1;
      if (flag_set[ST_CH0]) flag_q[ST_CH0] <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_irq <= 1'b0;
      current_input_number <= INPUT_ZERO;
    end else begin
      dma_irq <= |flag_q;
      current_input_number <= inp_q;
    end
  end

  always_comb begin
    rd_d = 8'h00;
    case (idx)
      IDX_CH0_HI: rd_d = hi_q[0];
      IDX_CH0_START: rd_d = cur_q[0][7:0];
      IDX_CH0_END: rd_d = end_q[0];
      IDX_CH1_HI: rd_d = hi_q[1];
      IDX_CH1_START: rd_d = cur_q[1][7:0];
      IDX_CH1_END: rd_d = end_q[1];
      IDX_CH0_CTL: rd_d = ctl_q[0];
      IDX_CH1_CTL: rd_d = ctl_q[1];
      IDX_ADC_BASE: rd_d = base_q;
      IDX_ADC_CTL: rd_d = actl_q;
      // flags set in the setup cycle are reported before the clear
      IDX_STATUS: rd_d = {inp_q, 1'b0, flag_q | flag_set};
      default: rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0;
    else if (psel && !penable && !pwrite) prdata <= {24'h0, rd_d};
  end

  // assertions
  property p_rd_clear;
    @(posedge pclk) disable iff (!presetn)
    (rd_en && idx == IDX_STATUS && !adc_last_ev && !(|ch_end_ev))
      |=> flag_q == 3'b000;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("no clear");

  property p_irq;
    @(posedge pclk) disable iff (!presetn) (|flag_q) |=> dma_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_adc_dis;
    @(posedge pclk) disable iff (!presetn) !actl_q[ACTL_EN] |=> inp_q == 4'h0;
  endproperty
  a_adc_dis: assert property (p_adc_dis) else $error("input not zero");

  property p_odd;
    @(posedge pclk) disable iff (!presetn)
    (adc_result_valid && actl_q[ACTL_EN]) |=> rf_we && !rf_addr[0]
      ##1 rf_we && rf_addr[0];
  endproperty
  a_odd: assert property (p_odd) else $error("byte order wrong");

  property p_step;
    @(posedge pclk) disable iff (!presetn)
    (chan_xfer_done[0] && ctl_q[0][CTL_EN] && !ch_end_ev[0] &&
     !wr_start[0] && !wr_hi[0] && !ctl_q[0][CTL_WORD])
      |=> cur_q[0] == $past(cur_q[0]) + 12'h001;
  endproperty
  a_step: assert property (p_step) else $error("step wrong");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
    (ch_end_ev[0] && !ctl_q[0][CTL_LOOP] && !(wr_en && idx == IDX_CH0_CTL))
      |=> !ctl_q[0][CTL_EN];
  endproperty
  a_single: assert property (p_single) else $error("not disabled");

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    adc_last_ev |=> inp_q == 4'h0 && adc_start;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");

  property p_aflag;
    @(posedge pclk) disable iff (!presetn)
    (adc_last_ev && actl_q[ACTL_IRQ]) |=> flag_q[ST_ADC] ##1 dma_irq;
  endproperty
  a_aflag: assert property (p_aflag) else $error("adc flag");

  property p_word_step;
    @(posedge pclk) disable iff (!presetn)
    (chan_xfer_done[1] && ctl_q[1][CTL_EN] && !ch_end_ev[1] &&
     !wr_start[1] && !wr_hi[1] && ctl_q[1][CTL_WORD])
      |=> cur_q[1] == $past(cur_q[1]) + STEP_WORD;
  endproperty
  a_word_step: assert property (p_word_step) else $error("word step");

  property p_reload;
    @(posedge pclk) disable iff (!presetn)
    (ch_end_ev[1] && !wr_start[1] && !wr_hi[1])
      |=> cur_q[1] == {hi_q[1][3:0], start_q[1]};
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");

  property p_loop_keep;
    @(posedge pclk) disable iff (!presetn)
    (ch_end_ev[1] && ctl_q[1][CTL_LOOP] && !(wr_en && idx == IDX_CH1_CTL))
      |=> ctl_q[1][CTL_EN];
  endproperty
  a_loop_keep: assert property (p_loop_keep) else $error("loop off");

  property p_ch1_flag;
    @(posedge pclk) disable iff (!presetn)
    (ch_end_ev[1] && ctl_q[1][CTL_IRQ]) |=> flag_q[ST_CH1];
  endproperty
  a_ch1_flag: assert property (p_ch1_flag) else $error("flag1");

  property p_ch0_flag;
    @(posedge pclk) disable iff (!presetn)
    (ch_end_ev[0] && ctl_q[0][CTL_IRQ]) |=> flag_q[ST_CH0];
  endproperty
  a_ch0_flag: assert property (p_ch0_flag) else $error("flag0");

  property p_no_aflag;
    @(posedge pclk) disable iff (!presetn)
    (!flag_q[ST_ADC] && !(adc_last_ev && actl_q[ACTL_IRQ]))
      |=> !flag_q[ST_ADC];
  endproperty
  a_no_aflag: assert property (p_no_aflag) else $error("stray flag");

  property p_scan_step;
    @(posedge pclk) disable iff (!presetn)
    (adc_result_valid && actl_q[ACTL_EN] && !adc_last_ev)
      |=> inp_q == $past(inp_q) + 4'h1;
  endproperty
  a_scan_step: assert property (p_scan_step) else $error("no step");

  property p_res_bytes;
    @(posedge pclk) disable iff (!presetn)
    (adc_result_valid && actl_q[ACTL_EN])
      |=> rf_wdata == $past(adc_result[9:2])
      ##1 rf_wdata == {$past(adc_result[1:0], 2), 6'h00};
  endproperty
  a_res_bytes: assert property (p_res_bytes) else $error("bad bytes");

  property p_res_addr;
    @(posedge pclk) disable iff (!presetn)
    (adc_result_valid && actl_q[ACTL_EN])
      |=> rf_addr == {$past(base_q[7:1]), $past(inp_q), 1'b0};
  endproperty
  a_res_addr: assert property (p_res_addr) else $error("bad address");

  property p_stat_input;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && idx == IDX_STATUS)
      |=> prdata[7:4] == $past(inp_q) && !prdata[3];
  endproperty
  a_stat_input: assert property (p_stat_input) else $error("input");

  property p_cur_read;
    @(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && idx == IDX_CH0_START)
      |=> prdata[7:0] == $past(cur_q[0][7:0]);
  endproperty
  a_cur_read: assert property (p_cur_read) else $error("not current");

  property p_dis_ignore;
    @(posedge pclk) disable iff (!presetn)
    (adc_result_valid && !actl_q[ACTL_EN] && !adc_pend_q) |=> !rf_we;
  endproperty
  a_dis_ignore: assert property (p_dis_ignore) else $error("taken");
endmodule : dmas_top
`default_nettype wire

// *** design/dmas_pkg.sv ***
// package: register offsets, field positions and reset values of the dma block
package dmas_pkg;
  // printed offsets are not multiples of four: kept as indices, byte = 4*index
  localparam logic [11:0] IDX_CH0_HI = 12'hfb2;
  localparam logic [11:0] IDX_CH0_START = 12'hfb3;
  localparam logic [11:0] IDX_CH0_END = 12'hfb4;
  localparam logic [11:0] IDX_CH1_HI = 12'hfba;
  localparam logic [11:0] IDX_CH1_START = 12'hfbb;
  localparam logic [11:0] IDX_CH1_END = 12'hfbc;
  localparam logic [11:0] IDX_ADC_BASE = 12'hfbd;
  localparam logic [11:0] IDX_ADC_CTL = 12'hfbe;
  localparam logic [11:0] IDX_STATUS = 12'hfbf;
  localparam logic [11:0] IDX_CH0_CTL = 12'hfb0;
  localparam logic [11:0] IDX_CH1_CTL = 12'hfb8;
  localparam int ADDR_W = 14;
  // general channel control fields
  localparam int CTL_EN = 7;
  localparam int CTL_LOOP = 6;
  localparam int CTL_IRQ = 4;
  localparam int CTL_WORD = 3;
  // adc control fields
  localparam int ACTL_EN = 7;
  localparam int ACTL_IRQ = 6;
  localparam int ACTL_CNT_LO = 0;
  // status fields
  localparam int ST_ADC = 2;
  localparam int ST_CH1 = 1;
  localparam int ST_CH0 = 0;
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [3:0] INPUT_ZERO = 4'h0;
  localparam logic [11:0] STEP_BYTE = 12'h001;
  localparam logic [11:0] STEP_WORD = 12'h002;
endpackage : dmas_pkg

// *** tb/dmas_adc_model.sv ***
// adc converter model: answers each conversion start after a delay
`timescale 1ns/1ps
`default_nettype none
module dmas_adc_model #(
  parameter int LAT = 20
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // conversion starts
  input wire logic kick,
  input wire logic adc_start,
  input wire logic [3:0] current_input_number,
  // result toward the block
  output logic adc_result_valid,
  output logic [9:0] adc_result
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      adc_result_valid <= 1'b0;
      adc_result <= 10'h000;
    end else begin
      adc_result_valid <= (cnt == 1);
      // result carries the input; lines toggle outside results
      adc_result <= (cnt == 1) ? {current_input_number, 6'h25} : ~adc_result;
      if (kick || adc_start) begin
        cnt <= LAT;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // dmas_adc_model
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the dma address and adc scan block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dmas_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, kick = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [1:0] chan_xfer_done = 2'b00;
  logic [1:0] chan_enable, chan_word;
  logic pready, pslverr, rf_we, adc_start, dma_irq, adc_result_valid;
  logic [9:0] adc_result;
  logic [11:0] rf_addr;
  logic [7:0] rf_wdata, rd;
  logic [3:0] mi, current_input_number;
  logic [23:0] chan_cur_addr, chan_end_addr;
  int fails = 0, cmp_count = 0, nrf = 0;
  always #20 pclk = ~pclk;
  dmas_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_xfer_done(chan_xfer_done),
    .adc_result_valid(adc_result_valid), .adc_result(adc_result),
    .rf_we(rf_we), .rf_addr(rf_addr), .rf_wdata(rf_wdata),
    .chan_cur_addr(chan_cur_addr), .chan_end_addr(chan_end_addr),
    .chan_enable(chan_enable), .chan_word(chan_word),
    .current_input_number(current_input_number), .adc_start(adc_start),
    .dma_irq(dma_irq)
  );
  dmas_adc_model adc_u (
    .pclk(pclk), .presetn(presetn), .kick(kick), .adc_start(adc_start),
    .current_input_number(current_input_number),
    .adc_result_valid(adc_result_valid), .adc_result(adc_result)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [7:0] v);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {a, 2'b00};
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 50) fails++;
      if (n > 50) test_done();
      @(posedge pclk);
    end
    rd = prdata[7:0];
    chk(32'(pslverr), 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk({24'h0, rd}, {24'h0, e});
  endtask
  task automatic xfer(input int ch, input int k);
    repeat (k) begin
      chan_xfer_done[ch] <= 1'b1;
      @(posedge pclk);
      chan_xfer_done[ch] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
  task automatic wt(input int tgt, input bit on_irq);
    int n;
    n = 0;
    while (nrf < tgt && !(on_irq && dma_irq === 1'b1)) begin
      n++;
      if (n > 500) fails++;
      if (n > 500) test_done();
      @(posedge pclk);
    end
  endtask
  // result bytes: inputs 0..2 in turn, high byte even, low bits odd
  always @(negedge pclk) begin
    if (rf_we === 1'b1) begin
      mi = 4'((nrf / 2) % 3);
      chk(32'(rf_addr), 32'({7'h39, mi, nrf[0]}));
      chk(32'(rf_wdata), nrf[0] ? 32'h40 : 32'({mi, 4'h9})); // bytes
      nrf++;
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(IDX_ADC_CTL, RST_CTL); // reset
    rdc(IDX_STATUS, 8'h00); // reset
    rdc(12'h100, 8'h00);
    apb(1'b1, IDX_CH0_HI, 8'h43);
    apb(1'b1, IDX_CH0_START, 8'hfe);
    apb(1'b1, IDX_CH0_END, 8'h01);
    apb(1'b1, IDX_CH0_CTL, 8'h90);
    repeat (2) @(posedge pclk);
    chk(32'(chan_end_addr[11:0]), 32'h401); // end
    chk(32'(chan_cur_addr[11:0]), 32'h3fe); // start
    xfer(0, 2);
    chk(32'(chan_cur_addr[11:0]), 32'h400); // carry
    rdc(IDX_CH0_START, 8'h00); // current
    xfer(0, 2);
    chk(32'(chan_cur_addr[11:0]), 32'h3fe); // reload
    chk(32'(chan_enable[0]), 32'h0); // single pass
    chk(32'(dma_irq), 32'h1); // line
    rdc(IDX_STATUS, 8'h01); // flag
    rdc(IDX_STATUS, 8'h00); // cleared
    chk(32'(dma_irq), 32'h0); // line
    apb(1'b1, IDX_CH1_HI, 8'h11);
    apb(1'b1, IDX_CH1_START, 8'h10);
    apb(1'b1, IDX_CH1_END, 8'h14);
    apb(1'b1, IDX_CH1_CTL, 8'hc8); // word mode, loop
    xfer(1, 2);
    chk(32'(chan_cur_addr[23:12]), 32'h114); // word
    chk(32'(chan_word[1]), 32'h1); // word
    chk(32'(chan_end_addr[23:12]), 32'h114); // end
    xfer(1, 1);
    chk(32'(chan_cur_addr[23:12]), 32'h110); // loop
    chk(32'(chan_enable[1]), 32'h1); // loop
    rdc(IDX_STATUS, 8'h00); // no irq
    apb(1'b1, IDX_CH1_CTL, 8'hd8);
    xfer(1, 3);
    rdc(IDX_STATUS, 8'h02); // ch1 flag
    apb(1'b1, IDX_ADC_BASE, 8'h72);
    apb(1'b1, IDX_ADC_CTL, 8'hc2); // reserved zero
    kick <= 1'b1;
    @(posedge pclk);
    kick <= 1'b0;
    wt(99, 1'b1);
    chk(32'(nrf), 32'd6); // last
    rdc(IDX_STATUS, 8'h04); // wrap
    wt(8, 1'b0);
    repeat (3) @(posedge pclk);
    rdc(IDX_STATUS, 8'h10); // next
    apb(1'b1, IDX_ADC_CTL, 8'h42);
    repeat (2) @(posedge pclk);
    chk(32'(current_input_number), 32'h0); // off
    repeat (30) @(posedge pclk);
    chk(32'(nrf), 32'd8); // ignored
    test_done();
  end
endmodule // testbench
`default_nettype wire
